// >>> nvmc_top.sv
/*
  Nonvolatile memory control registers behind an AXI4-Lite slave: address,
  data, control and unlock registers, 32-word write latches, read and
  self-timed program/erase sequencing toward the memory array.
  Assumes a memory array answering a read one cycle after o_mem_re, a
  same-clock write-protect level, and a separate power-on reset.
*/
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module nvmc_top #(
  parameter int PROG_CYCLES = nvmc_pkg::PROG_CYCLES
) (
  // clock and resets
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_por_n,
  // axi4-lite write
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [nvmc_pkg::AXI_AW-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // axi4-lite read
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [nvmc_pkg::AXI_AW-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // memory array
  output logic [14:0] o_mem_addr,
  output logic o_mem_region,
  output logic o_mem_re,
  output logic o_mem_we,
  output logic o_mem_erase,
  output logic [13:0] o_mem_wdata,
  input wire logic [13:0] i_mem_rdata,
  input wire logic i_mem_wp,
  // completion event
  output logic o_program_done_flag
);
  import nvmc_pkg::*;

  if (PROG_CYCLES < 1 || PROG_CYCLES > 4095) begin : g_chk
    $error("PROG_CYCLES out of range");
  end

  localparam logic [11:0] PROG_CNT = 12'(PROG_CYCLES);

  // bus slave state
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [AXI_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] wd, wd_nxt, rdata_r, rdata_nxt, rd_mux;
  logic [3:0] strb_r, strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rd_hit, wr_fire, hit_addr, hit_data, hit_ctrl, hit_unlk, sw_ctrl;
  // control state
  nvmc_state_t state_r, state_nxt;
  logic [6:0] ctrl_r, ctrl_nxt;
  logic [15:0] adr_r, adr_nxt;
  logic [13:0] data_r, data_nxt;
  logic [1:0] ul_r, ul_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic mark_r, mark_nxt, fault_set, lat_we, lat_clr;
  logic mem_re_nxt, mem_we_nxt, mem_erase_nxt, done_nxt;
  logic [14:0] mem_addr_nxt;
  logic [13:0] mem_wdata_nxt;
  logic [13:0] latch_r [ROW_WORDS];

  assign o_axi_awready = !aw_ok_r && !bvalid_r;
  assign o_axi_wready = !w_ok_r && !bvalid_r;
  assign o_axi_arready = !rvalid_r;
  assign o_axi_bvalid = bvalid_r;
  assign o_axi_bresp = bresp_r;
  assign o_axi_rvalid = rvalid_r;
  assign o_axi_rdata = rdata_r;
  assign o_axi_rresp = rresp_r;
  assign wr_fire = aw_ok_r && w_ok_r;
  assign hit_addr = aw_addr_r == {IDX_ADDR, 2'h0};
  assign hit_data = aw_addr_r == {IDX_DATA, 2'h0};
  assign hit_ctrl = aw_addr_r == {IDX_CTRL, 2'h0};
  assign hit_unlk = aw_addr_r == {IDX_UNLK, 2'h0};
  assign sw_ctrl = wr_fire && hit_ctrl && strb_r[0];
  assign o_mem_region = ctrl_r[CB_REGION];

  // read mux; bit 7 of control is absent and the unlock pattern is not kept
  always_comb begin : rd_decode
    rd_hit = 1'b1;
    case (i_axi_araddr)
      {IDX_ADDR, 2'h0}: rd_mux = {16'h0000, adr_r};
      {IDX_DATA, 2'h0}: rd_mux = {18'h00000, data_r};
      {IDX_CTRL, 2'h0}: rd_mux = {25'h0000000, ctrl_r};
      {IDX_UNLK, 2'h0}: rd_mux = 32'h00000000;
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin : bus_next
    aw_ok_nxt = aw_ok_r;
    aw_addr_nxt = aw_addr_r;
    w_ok_nxt = w_ok_r;
    wd_nxt = wd;
    strb_nxt = strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (i_axi_awvalid && o_axi_awready) begin
      aw_ok_nxt = 1'b1;
      aw_addr_nxt = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      w_ok_nxt = 1'b1;
      wd_nxt = i_axi_wdata;
      strb_nxt = i_axi_wstrb;
    end
    if (wr_fire) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (hit_addr || hit_data || hit_ctrl || hit_unlk) ? RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && i_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_mux;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && i_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin : bus_regs
    if (!i_rst_n) begin
      aw_ok_r <= 1'b0;
      aw_addr_r <= '0;
      w_ok_r <= 1'b0;
      wd <= 32'h00000000;
      strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_ok_r <= w_ok_nxt;
      wd <= wd_nxt;
      strb_r <= strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  always_comb begin : ctrl_next
    ctrl_nxt = ctrl_r;
    ul_nxt = ul_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    adr_nxt = adr_r;
    mark_nxt = mark_r;
    mem_re_nxt = 1'b0;
    mem_we_nxt = 1'b0;
    mem_erase_nxt = 1'b0;
    mem_addr_nxt = o_mem_addr;
    mem_wdata_nxt = o_mem_wdata;
    done_nxt = 1'b0;
    fault_set = 1'b0;
    lat_we = 1'b0;
    lat_clr = 1'b0;
    if (wr_fire && hit_addr) begin
      if (strb_r[0]) adr_nxt[7:0] = wd[7:0];
      if (strb_r[1]) adr_nxt[15:8] = wd[15:8];
    end
    // any other write between the pattern bytes and the start breaks the unlock
    if (wr_fire) begin
      if (hit_unlk && strb_r[0]) begin
        if (wd[7:0] == UNLOCK_1) begin
          ul_nxt = 2'h1;
        end else if (wd[7:0] == UNLOCK_2 && ul_r == 2'h1) begin
          ul_nxt = 2'h2;
        end else begin
          fault_set = ul_r != 2'h0;
          ul_nxt = 2'h0;
        end
      end else begin
        fault_set = (ul_r != 2'h0) && !(sw_ctrl && wd[CB_WRITE] && ul_r == 2'h2);
        ul_nxt = 2'h0;
      end
    end
    if (sw_ctrl) begin
      ctrl_nxt[CB_FAULT] = wd[CB_FAULT];
      ctrl_nxt[CB_ALLOW] = wd[CB_ALLOW];
      if (state_r == ST_IDLE) begin
        ctrl_nxt[CB_REGION] = wd[CB_REGION];
        ctrl_nxt[CB_LATCH] = wd[CB_LATCH];
        if (wd[CB_ERASE]) ctrl_nxt[CB_ERASE] = 1'b1;
      end
    end
    case (state_r)
      ST_IDLE: begin
        // a marker surviving reset means a self-write was cut short
        if (mark_r) begin
          fault_set = 1'b1;
          mark_nxt = 1'b0;
        end
        if (sw_ctrl && wd[CB_WRITE] && ul_r == 2'h2 && ctrl_nxt[CB_ALLOW]) begin
          mem_addr_nxt = adr_nxt[14:0];
          if (!ctrl_nxt[CB_ERASE] && ctrl_nxt[CB_LATCH]) begin
            lat_we = 1'b1;
          end else if (i_mem_wp) begin
            fault_set = 1'b1;
          end else begin
            ctrl_nxt[CB_WRITE] = 1'b1;
            mark_nxt = 1'b1;
            cnt_nxt = 12'h000;
            if (ctrl_nxt[CB_ERASE]) begin
              mem_erase_nxt = 1'b1;
              cnt_nxt = PROG_CNT;
              state_nxt = ST_TIME;
            end else if (ctrl_nxt[CB_REGION]) begin
              mem_we_nxt = 1'b1;
              mem_wdata_nxt = data_r;
              cnt_nxt = PROG_CNT;
              state_nxt = ST_TIME;
            end else begin
              state_nxt = ST_ROW;
            end
          end
        end else if (sw_ctrl && wd[CB_READ]) begin
          ctrl_nxt[CB_READ] = 1'b1;
          mem_re_nxt = 1'b1;
          mem_addr_nxt = adr_nxt[14:0];
          state_nxt = ST_READ;
        end
      end
      ST_READ: state_nxt = ST_RCAP;
      ST_RCAP: begin
        ctrl_nxt[CB_READ] = 1'b0;
        state_nxt = ST_IDLE;
      end
      ST_ROW: begin
        mem_we_nxt = 1'b1;
        mem_addr_nxt = {adr_r[14:5], cnt_r[4:0]};
        mem_wdata_nxt = latch_r[cnt_r[4:0]];
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == ROW_LAST) begin
          lat_clr = 1'b1;
          cnt_nxt = PROG_CNT;
          state_nxt = ST_TIME;
        end
      end
      ST_TIME: begin
        // software zero writes cannot touch the start bit while timing
        cnt_nxt = cnt_r - 12'h001;
        if (cnt_r == 12'h001) begin
          ctrl_nxt[CB_WRITE] = 1'b0;
          ctrl_nxt[CB_ERASE] = 1'b0;
          done_nxt = ctrl_r[CB_REGION];
          mark_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (fault_set) ctrl_nxt[CB_FAULT] = 1'b1;
    if (!i_rst_n) mark_nxt = mark_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin : ctrl_regs
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RESET;
      ul_r <= 2'h0;
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
      adr_r <= ADDR_RESET;
      o_mem_re <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_erase <= 1'b0;
      o_mem_addr <= 15'h0000;
      o_mem_wdata <= 14'h0000;
      o_program_done_flag <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ul_r <= ul_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      adr_r <= adr_nxt;
      o_mem_re <= mem_re_nxt;
      o_mem_we <= mem_we_nxt;
      o_mem_erase <= mem_erase_nxt;
      o_mem_addr <= mem_addr_nxt;
      o_mem_wdata <= mem_wdata_nxt;
      o_program_done_flag <= done_nxt;
    end
  end

  // operation marker is reset only by power-on, so a warm reset can be detected
  always_ff @(posedge i_clk_sys or negedge i_por_n) begin : mark_reg
    if (!i_por_n) mark_r <= 1'b0;
    else mark_r <= mark_nxt;
  end

  always_comb begin : data_next
    data_nxt = data_r;
    if (wr_fire && hit_data) begin
      if (strb_r[0]) data_nxt[7:0] = wd[7:0];
      if (strb_r[1]) data_nxt[13:8] = wd[13:8];
    end
    if (state_r == ST_RCAP) data_nxt = i_mem_rdata;
  end

  // no reset on purpose: contents survive every reset
  always_ff @(posedge i_clk_sys) begin : data_reg
    data_r <= data_nxt;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin : latch_regs
    if (!i_rst_n) begin
      for (int i = 0; i < ROW_WORDS; i++) latch_r[i] <= LATCH_RESET;
    end else if (lat_clr) begin
      for (int i = 0; i < ROW_WORDS; i++) latch_r[i] <= LATCH_RESET;
    end else if (lat_we) begin
      latch_r[adr_nxt[4:0]] <= data_r;
    end
  end

  // fault flag is only meaningful once the start bit is low again
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_read_clear: assert property ($rose(ctrl_r[CB_READ]) |-> ##2 !ctrl_r[CB_READ])
    else $error("read start not cleared after two cycles");
  a_read_data: assert property (state_r == ST_RCAP |=> data_r == $past(i_mem_rdata))
    else $error("read data not captured");
  a_fault_sticky: assert property (ctrl_r[CB_FAULT] && !sw_ctrl |=> ctrl_r[CB_FAULT])
    else $error("fault flag cleared by hardware");
  a_start_unlock: assert property ($rose(ctrl_r[CB_WRITE]) |-> $past(ul_r) == 2'h2)
    else $error("write start without unlock");
  a_start_allow: assert property ($rose(ctrl_r[CB_WRITE]) |-> ctrl_r[CB_ALLOW])
    else $error("write start while not allowed");
  a_start_hold: assert property (state_r == ST_TIME && cnt_r > 12'h001
    |=> ctrl_r[CB_WRITE])
    else $error("write start dropped early");
  a_timed_end: assert property (state_r == ST_TIME && cnt_r == 12'h001
    |=> !ctrl_r[CB_WRITE])
    else $error("write start not cleared at end");
  a_done_pulse: assert property (o_program_done_flag
    |-> !ctrl_r[CB_WRITE] && ctrl_r[CB_REGION])
    else $error("done flag without completion");
  a_latch_reset: assert property (lat_clr
    |=> latch_r[0] == LATCH_RESET && latch_r[31] == LATCH_RESET)
    else $error("latches not reset after row write");
  a_erase_sel: assert property (o_mem_erase |-> ctrl_r[CB_ERASE] && ctrl_r[CB_WRITE])
    else $error("erase without erase select");
  a_latch_only: assert property (o_mem_we |-> !ctrl_r[CB_LATCH] || ctrl_r[CB_ERASE])
    else $error("memory write in latch-only mode");
  a_broken_unlock: assert property (wr_fire && hit_addr && ul_r != 2'h0
    |=> ctrl_r[CB_FAULT])
    else $error("broken unlock not flagged");

  c_read: cover property (state_r == ST_RCAP);
  c_erase: cover property (o_mem_erase);
  c_row: cover property (lat_clr);
  c_fault: cover property ($rose(ctrl_r[CB_FAULT]));
endmodule : nvmc_top
`default_nettype wire

// >>> nvmc_pkg.sv
/*
  Constants for the nonvolatile memory control registers: register indices,
  control bit positions, unlock pattern, reset values, timing and FSM states.
  Assumes a 125 MHz system clock and 32-bit AXI4-Lite access.
*/
`default_nettype none
package nvmc_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ADDR = 16'h1C8C;
  localparam logic [15:0] IDX_DATA = 16'h1C8E;
  localparam logic [15:0] IDX_CTRL = 16'h1C90;
  localparam logic [15:0] IDX_UNLK = 16'h1C91;
  localparam int AXI_AW = 18;
  // control bit positions
  localparam int CB_REGION = 6;
  localparam int CB_LATCH = 5;
  localparam int CB_ERASE = 4;
  localparam int CB_FAULT = 3;
  localparam int CB_ALLOW = 2;
  localparam int CB_WRITE = 1;
  localparam int CB_READ = 0;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] UNLOCK_1 = 8'h55;
  localparam logic [7:0] UNLOCK_2 = 8'hAA;
  localparam logic [13:0] LATCH_RESET = 14'h3FFF;
  localparam int ROW_WORDS = 32;
  localparam logic [11:0] ROW_LAST = 12'h01F;
  // self-timed program/erase; time value is a plain default
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_RCAP = 5'h04,
    ST_ROW = 5'h08,
    ST_TIME = 5'h10
  } nvmc_state_t;
endpackage : nvmc_pkg
`default_nettype wire

// >>> nvm_control_registers_tb.sv
/*
  Self-checking bench for nvmc_top: registers over AXI4-Lite, read, unlock,
  program/erase, latch loads, faults and reset during a write.
  Assumes nvmc_pkg is compiled first; the bench plays the memory array.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module nvm_control_registers_tb;
  import nvmc_pkg::*;
  localparam int PC = 4;
  localparam logic [17:0] A_ADR = {IDX_ADDR, 2'b00};
  localparam logic [17:0] A_DAT = {IDX_DATA, 2'b00};
  localparam logic [17:0] A_CTL = {IDX_CTRL, 2'b00};
  localparam logic [17:0] A_UNL = {IDX_UNLK, 2'b00};
  localparam logic [17:0] A_BAD = 18'h00100;
  logic clk, rst_n, por_n, awvalid, wvalid, bready, arvalid, rready, wp;
  logic awready, wready, bvalid, arready, rvalid, re, we, er, region, done;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, v;
  logic [3:0] wstrb, s;
  logic [1:0] bresp, rresp, rs, bs;
  logic [14:0] maddr;
  logic [13:0] mwd, mem_val, rd_word, dat, and_wd, w3_wd, last_wd;
  logic [15:0] adr;
  int mismatches, compares, we_cnt, er_cnt, done_cnt, re_cnt;

  nvmc_top #(.PROG_CYCLES(PC)) dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_por_n(por_n),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
    .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .o_mem_addr(maddr), .o_mem_region(region), .o_mem_re(re), .o_mem_we(we),
    .o_mem_erase(er), .o_mem_wdata(mwd), .i_mem_rdata(mem_val), .i_mem_wp(wp),
    .o_program_done_flag(done)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // array-side pulse monitor; pre-edge values keep it race free
  // read word shows only the cycle after the read pulse, so a late capture fails
  always @(posedge clk) begin
    mem_val <= (re === 1'b1) ? rd_word : 14'h0000;
    if (re === 1'b1) re_cnt++;
    if (we === 1'b1) begin
      we_cnt++;
      and_wd &= mwd;
      last_wd = mwd;
      if (maddr[4:0] == 5'h03) w3_wd = mwd;
    end
    if (er === 1'b1) er_cnt++;
    if (done === 1'b1) done_cnt++;
  end

  function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] n, logic [1:0] st);
    return {st[1] ? n[15:8] : o[15:8], st[0] ? n[7:0] : o[7:0]};
  endfunction : mrg

  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task hang;
    mismatches++;
    $display("[ERR] %0t wait bound used up", $time);
    end_of_test();
  endtask : hang

  // ready is sampled mid-cycle; it only moves after rising edges
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    bit ad, wd, ah, wh;
    n = 0;
    ad = 0;
    wd = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= st;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ah = awready && !ad;
      wh = wready && !wd;
      @(posedge clk);
      if (ah) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wd = 1;
      end
      if (++n > 50) hang();
    end
    do begin
      @(negedge clk);
      if (++n > 100) hang();
    end while (bvalid !== 1'b1);
    bs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [17:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 50) hang();
    end while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      if (++n > 100) hang();
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      rd(A_CTL);
      if (++n > 100) hang();
    end while (rv[b] !== 1'b0);
  endtask : wait_bit

  // broken inserts a foreign write inside the unlock pattern
  task automatic start(input logic [7:0] c, input bit broken);
    we_cnt = 0;
    er_cnt = 0;
    done_cnt = 0;
    and_wd = LATCH_RESET;
    wr(A_UNL, {24'h0, UNLOCK_1}, 4'h1);
    if (broken) begin
      wr(A_ADR, {16'h0, adr}, 4'h3);
      rd(A_CTL);
      `CHK(rv[3], 1'b1)
    end
    wr(A_UNL, {24'h0, UNLOCK_2}, 4'h1);
    wr(A_CTL, {24'h0, c}, 4'h1);
  endtask : start

  initial begin
    {rst_n, por_n, awvalid, wvalid, bready, arvalid, rready, wp} = '0;
    {awaddr, araddr, wdata, wstrb, rd_word} = '0;
    {mismatches, compares, we_cnt, er_cnt, done_cnt, re_cnt} = '0;
    void'($urandom(32'h5A42));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd(A_CTL);
    `CHK(rv, 32'h0)
    `CHK(rs, RESP_OKAY)
    rd(A_UNL);
    `CHK(rv, 32'h0)
    rd(A_ADR);
    `CHK(rv, {16'h0, ADDR_RESET})
    adr = ADDR_RESET;
    rd(A_BAD);
    `CHK(rs, RESP_DECERR)
    wr(A_BAD, 32'hFFFFFFFF, 4'hF);
    `CHK(bs, RESP_DECERR)
    for (int i = 0; i < 6; i++) begin
      s = 4'(((i + 2) % 3) + 1);
      v = $urandom;
      wr(A_ADR, v, s);
      adr = mrg(adr, v[15:0], s[1:0]);
      rd(A_ADR);
      `CHK(rv, {16'h0, adr})
      v = $urandom;
      wr(A_DAT, v, s);
      dat = 14'(mrg({2'b00, dat}, v[15:0], s[1:0]));
      rd(A_DAT);
      `CHK(rv, {18'h0, dat})
    end
    wr(A_CTL, 32'hE4, 4'h1);
    rd(A_CTL);
    `CHK(rv, 32'h64)
    `CHK(region, 1'b1)
    wr(A_CTL, 32'h08, 4'h1);
    rd(A_CTL);
    `CHK(rv, 32'h08)
    wr(A_CTL, 32'h40, 4'h1);
    rd(A_CTL);
    `CHK(rv, 32'h40)
    rd_word = 14'($urandom);
    wr(A_CTL, 32'h41, 4'h1);
    wait_bit(0);
    `CHK(re_cnt, 1)
    dat = rd_word;
    rd(A_DAT);
    `CHK(rv, {18'h0, dat})
    `CHK(maddr, adr[14:0])
    start(8'h46, 1'b0);
    wr(A_CTL, 32'h40, 4'h1);
    wait_bit(1);
    `CHK(we_cnt, 1)
    `CHK(done_cnt, 1)
    `CHK(last_wd, dat)
    start(8'h42, 1'b0);
    wait_bit(1);
    `CHK(we_cnt, 0)
    start(8'h46, 1'b1);
    wait_bit(1);
    `CHK(rv, 32'h44)
    `CHK(we_cnt, 0)
    wr(A_CTL, 32'h40, 4'h1);
    start(8'h56, 1'b0);
    wait_bit(1);
    `CHK(er_cnt, 1)
    `CHK(rv[4], 1'b0)
    `CHK(done_cnt, 1)
    wp <= 1'b1;
    start(8'h46, 1'b0);
    wait_bit(1);
    `CHK(rv[3], 1'b1)
    `CHK(we_cnt, 0)
    wp <= 1'b0;
    adr = {adr[15:5], 5'h03};
    wr(A_ADR, {16'h0, adr}, 4'h3);
    dat = 14'($urandom);
    wr(A_DAT, {18'h0, dat}, 4'h3);
    wr(A_CTL, 32'h00, 4'h1);
    start(8'h26, 1'b0);
    wait_bit(1);
    `CHK(we_cnt + er_cnt, 0)
    start(8'h06, 1'b0);
    wait_bit(1);
    `CHK(we_cnt, ROW_WORDS)
    `CHK(w3_wd, dat)
    `CHK(done_cnt, 0)
    start(8'h06, 1'b0);
    wait_bit(1);
    `CHK(and_wd, LATCH_RESET)
    // a 32-word row is long enough to be cut by reset
    start(8'h06, 1'b0);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTL);
    `CHK(rv, 32'h08)
    rd(A_DAT);
    `CHK(rv, {18'h0, dat})
    end_of_test();
  end
endmodule : nvm_control_registers_tb
`default_nettype wire
